//--- hdl/nrgd_core.v
// nrzi read checking, correction cycle close and gap detection
`timescale 1ns/1ps
`default_nettype none
`include "nrgd_map.vh"

module nrgd_core (
  // clock and reset
  input wire core_clk_i,
  input wire resetn_i,
  // register port
  input wire [`NRGD_ADDR_W-1:0] addr_i,
  input wire [`NRGD_DATA_W-1:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [`NRGD_DATA_W-1:0] rdata_o,
  // transport pins
  input wire read_char_detect_i,
  input wire [8:0] read_char_data_i,
  input wire transport_char_clock_i,
  // formatter control, same clock
  input wire drive_setup_pulse_i,
  input wire cmd_launch_i,
  input wire reverse_i,
  input wire write_op_i,
  input wire reading_i,
  input wire gap_timer_done_i,
  input wire longit_char_done_i,
  input wire crc_mismatch_i,
  input wire correctable_i,
  input wire incorrectable_i,
  input wire [3:0] err_track_i,
  // results
  output reg [8:0] char_o,
  output reg char_valid_o,
  output reg end_record_strobe_o,
  output wire forward_longit_strobe_o,
  output wire longitudinal_ok_o,
  output wire slave_change_flag_o,
  output wire gap_count_eight_o,
  output reg gap_detected_o,
  output reg tape_mark_flag_o,
  output reg cycle1_o,
  output reg cycle2_o,
  output reg cycle3_o
);

  // odd parity on a tape character is good
  function parity_ok;
    input [8:0] d;
    begin
      parity_ok = ^d;
    end
  endfunction

  // register address decode, shared by the write and read paths
  function hit;
    input [`NRGD_ADDR_W-1:0] a;
    input [`NRGD_ADDR_W-1:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // synchronisers for transport pins
  // the third stage only feeds the edge detectors below
  reg rcd_s1;
  reg rcd_s2;
  reg rcd_s3;
  reg tc_s1;
  reg tc_s2;
  reg tc_s3;
  reg [8:0] rdat_s1;
  reg [8:0] rdat_s2;

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rcd_s1 <= 1'b0;
      rcd_s2 <= 1'b0;
      rcd_s3 <= 1'b0;
      tc_s1 <= 1'b0;
      tc_s2 <= 1'b0;
      tc_s3 <= 1'b0;
      rdat_s1 <= 9'h000;
      rdat_s2 <= 9'h000;
    end else begin
      rcd_s1 <= read_char_detect_i;
      rcd_s2 <= rcd_s1;
      rcd_s3 <= rcd_s2;
      tc_s1 <= transport_char_clock_i;
      tc_s2 <= tc_s1;
      tc_s3 <= tc_s2;
      rdat_s1 <= read_char_data_i;
      rdat_s2 <= rdat_s1;
    end
  end

  // data pins settle before the detect pulse, so stage two is stable here
  wire read_char_strobe = rcd_s2 & ~rcd_s3;
  wire char_tick = tc_s2 & ~tc_s3;

  // 200 bpi gap clock as a one-cycle enable
  // free running: its phase against the tape is arbitrary, so the first
  // gap count after the last character may come up to one tick early
  reg [`NRGD_DIV_W-1:0] div_cnt;
  wire gap_tick = (div_cnt == `NRGD_GAP_CLK_CYCLES - 1);

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i)
      div_cnt <= {`NRGD_DIV_W{1'b0}};
    else if (gap_tick)
      div_cnt <= {`NRGD_DIV_W{1'b0}};
    else
      div_cnt <= div_cnt + 1'b1;
  end

  // control register
  // a new select takes effect only at the next drive setup
  reg [4:0] ctrl;
  wire [2:0] sel_req = ctrl[`NRGD_CTRL_SEL_MSB:`NRGD_CTRL_SEL_LSB];
  wire short_opt = ctrl[`NRGD_CTRL_SHORT_BIT];
  wire no_corr = ctrl[`NRGD_CTRL_NOCORR_BIT];

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i)
      ctrl <= `NRGD_CTRL_RESET;
    else if (wr_i && hit(addr_i, `NRGD_CTRL_OFS))
      ctrl <= wdata_i[4:0];
  end

  // held select and slave change
  reg [2:0] sel_held;
  assign slave_change_flag_o = (sel_req != sel_held);

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i)
      sel_held <= 3'h0;
    else if (drive_setup_pulse_i)
      sel_held <= sel_req;
  end

  // longitudinal check register
  // it sees the raw tracks, before any cycle 3 repair
  reg [8:0] lrc;
  assign longitudinal_ok_o = (lrc == 9'h000) | cycle3_o;
  assign forward_longit_strobe_o = longit_char_done_i & ~reverse_i;

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i)
      lrc <= 9'h000;
    else if (drive_setup_pulse_i)
      lrc <= 9'h000;
    else if (read_char_strobe)
      lrc <= lrc ^ rdat_s2;
  end

  // cycle 3 correction of the read path
  wire vrc = ~parity_ok(rdat_s2);
  // an incorrectable error leaves the data untouched
  wire [8:0] fix_mask;
  genvar g;
  generate
    for (g = 0; g < 9; g = g + 1) begin : g_fix
      assign fix_mask[g] = cycle3_o & vrc & ~incorrectable_i
                           & (err_track_i == g);
    end
  endgenerate

  // maintenance data: holds the last character, the check char at record end
  // char_o and the maintenance copy carry the same repaired value
  reg [8:0] maint_data;

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      char_o <= 9'h000;
      char_valid_o <= 1'b0;
      maint_data <= 9'h000;
    end else begin
      char_valid_o <= read_char_strobe;
      if (read_char_strobe) begin
        char_o <= rdat_s2 ^ fix_mask;
        maint_data <= rdat_s2 ^ fix_mask;
      end
    end
  end

  // correction cycle flip-flops
  // cycle 1: cyclic error seen on a forward read
  // cycle 2: reverse pass that locates the failing track
  // cycle 3: forward reread that repairs the track
  // later assignments win, so the order of the ifs matters:
  // launch ends cycle 3, then a new cyclic error may start cycle 1,
  // and a select change overrides everything for cycles 1 and 2
  wire crc_err_set = forward_longit_strobe_o & crc_mismatch_i;

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cycle1_o <= 1'b0;
      cycle2_o <= 1'b0;
      cycle3_o <= 1'b0;
    end else begin
      if (drive_setup_pulse_i) begin
        if (cycle2_o) begin
          cycle1_o <= 1'b0;
          cycle2_o <= 1'b0;
          cycle3_o <= ~reverse_i & ~write_op_i;
        end else if (cycle1_o) begin
          cycle1_o <= reverse_i;
          cycle2_o <= reverse_i;
        end
      end

      if (cmd_launch_i && correctable_i && cycle3_o)
        cycle3_o <= 1'b0;

      if (crc_err_set && !cycle3_o && !no_corr && !slave_change_flag_o)
        cycle1_o <= 1'b1;

      // cycle 3 is left alone so a started correction completes
      if (slave_change_flag_o) begin
        cycle1_o <= 1'b0;
        cycle2_o <= 1'b0;
      end
    end
  end

  // short record and tape mark detection
  // a tape mark is two lone characters a few cells apart, then silence;
  // the spacing counter runs on the transport character clock, so the
  // window is measured in tape cells, not core clocks
  // limitation: the window only reopens after reading_i drops
  reg mark_window_ff;
  reg brief_char_stage_one;
  reg brief_char_stage_two;
  reg [3:0] space_cnt;
  reg [3:0] char_cnt;
  wire no_char_read = ~brief_char_stage_one & ~brief_char_stage_two & (char_cnt == 4'h0);
  wire [3:0] min_len = short_opt ? `NRGD_MIN_SHORT : `NRGD_MIN_LEN;
  wire mark_path = mark_window_ff & brief_char_stage_two & ~brief_char_stage_one;
  wire gap_count_enable = mark_path | (char_cnt >= min_len);

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mark_window_ff <= 1'b0;
      brief_char_stage_one <= 1'b0;
      brief_char_stage_two <= 1'b0;
      space_cnt <= `NRGD_SPACE_PRESET;
      char_cnt <= 4'h0;
    end else if (!reading_i) begin
      mark_window_ff <= 1'b0;
      brief_char_stage_one <= 1'b0;
      brief_char_stage_two <= 1'b0;
      space_cnt <= `NRGD_SPACE_PRESET;
      char_cnt <= 4'h0;
    end else if (read_char_strobe) begin
      // saturates so a long record cannot wrap back below the minimum
      if (char_cnt != `NRGD_CCNT_FULL)
        char_cnt <= char_cnt + 4'h1;

      if (no_char_read) begin
        mark_window_ff <= 1'b1;
        brief_char_stage_one <= 1'b1;
        space_cnt <= `NRGD_SPACE_PRESET;
      end else if (brief_char_stage_one) begin
        brief_char_stage_one <= 1'b0;
        if (space_cnt >= `NRGD_SPACE_LO)
          brief_char_stage_two <= 1'b1;
        else
          mark_window_ff <= 1'b0;
      end else begin
        // a third character means a record, not a mark
        mark_window_ff <= 1'b0;
        brief_char_stage_two <= 1'b0;
      end

    end else if (char_tick && brief_char_stage_one) begin
      if (space_cnt == `NRGD_SPACE_FULL) begin
        mark_window_ff <= 1'b0;
        brief_char_stage_one <= 1'b0;
      end else begin
        space_cnt <= space_cnt + 4'h1;
      end
    end
  end

  // shutdown counter
  // stops at 15 so the end strobe fires once per gap
  // every character clears it, so a noisy record keeps it low
  reg [3:0] gap_cnt;
  wire gap_counter_clear = read_char_strobe | ~reading_i;
  wire gap_inc = gap_tick & gap_count_enable & (gap_cnt != `NRGD_GAP_FULL)
                 & (~write_op_i | gap_timer_done_i);
  assign gap_count_eight_o = (gap_cnt == `NRGD_GAP_EIGHT);
  // window closes once the stop-motion delay has been started at 15
  wire nonstandard_gap_err = write_op_i & read_char_strobe
                             & (gap_cnt >= `NRGD_GAP_EIGHT)
                             & (gap_cnt != `NRGD_GAP_FULL);

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i)
      gap_cnt <= 4'h0;
    else if (gap_counter_clear)
      gap_cnt <= 4'h0;
    else if (gap_inc)
      gap_cnt <= gap_cnt + 4'h1;
  end

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      end_record_strobe_o <= 1'b0;
      gap_detected_o <= 1'b0;
      tape_mark_flag_o <= 1'b0;
    end else begin
      end_record_strobe_o <= gap_inc & ~gap_counter_clear
                             & (gap_cnt == `NRGD_GAP_LAST);
      if (drive_setup_pulse_i) begin
        // a new operation forgets the last gap and mark
        gap_detected_o <= 1'b0;
        tape_mark_flag_o <= 1'b0;
      end
      // an event in the setup cycle still wins over the clear
      if (gap_inc && !gap_counter_clear && gap_cnt == `NRGD_GAP_LAST)
        gap_detected_o <= 1'b1;
      if (mark_path && gap_count_eight_o)
        tape_mark_flag_o <= 1'b1;
    end
  end

  // error register, set beats a same-cycle clear
  reg [2:0] err;
  wire [2:0] err_set;
  wire [2:0] err_clr = (wr_i && hit(addr_i, `NRGD_ERR_OFS)) ? wdata_i[2:0] : 3'h0;
  assign err_set[`NRGD_ERR_CRC_BIT] = crc_err_set;
  assign err_set[`NRGD_ERR_FLE_BIT] = forward_longit_strobe_o & ~longitudinal_ok_o;
  assign err_set[`NRGD_ERR_NSG_BIT] = nonstandard_gap_err;

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i)
      err <= `NRGD_ERR_RESET;
    else
      err <= (err & ~err_clr) | err_set;
  end

  // read data, one cycle after the strobe
  // unmapped addresses read as zero; data is zero outside its cycle
  reg [`NRGD_DATA_W-1:0] next_rdata;

  always @* begin
    next_rdata = {`NRGD_DATA_W{1'b0}};
    if (hit(addr_i, `NRGD_CTRL_OFS))
      next_rdata[4:0] = ctrl;
    else if (hit(addr_i, `NRGD_STAT_OFS))
      next_rdata[6:0] = {mark_window_ff, tape_mark_flag_o, gap_detected_o,
                         slave_change_flag_o, cycle3_o, cycle2_o, cycle1_o};
    else if (hit(addr_i, `NRGD_ERR_OFS))
      next_rdata[2:0] = err;
    else if (hit(addr_i, `NRGD_MAINT_OFS))
      next_rdata[8:0] = maint_data;
    else if (hit(addr_i, `NRGD_LRC_OFS))
      next_rdata[8:0] = lrc;
  end

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i)
      rdata_o <= {`NRGD_DATA_W{1'b0}};
    else if (rd_i)
      rdata_o <= next_rdata;
    else
      rdata_o <= {`NRGD_DATA_W{1'b0}};
  end

endmodule // nrgd_core
`default_nettype wire

//--- shared/nrgd_map.vh
// constants for the read check and gap detect block
// Summary of operation
// - forward strobe after check char sets cyclic error
// - cycle 3 blocks setting cycle 1
// - launch clears cycle 3 when correctable
// - select compare raises slave change; setup clears
// - slave change aborts cycles 1 and 2
// - setup clears check register; ones toggle bits
// - nonzero check register after check char errors
// - longitudinal ok forced true in cycle 3
// - false match sets format/longitudinal error bit
// - reverse read ignores the longitudinal character
// - last character kept in maintenance register
// - read pulses clear gap counter; gap clock counts
// - write waits for gap timer before counting
// - count 15 gives end strobe and gap flag
// - data at count 8..14 in write: nonstandard gap
// - first char sets window and stage one
// - spacing counter preset 6, counts char clock
// - second char at 12..15 advances, enables counting
// - isolated pair plus count 8 sets tape mark
// - record shutdown needs 10 character pulses
// - short option lowers minimum length to 4
// - cycle 3 complements error track on parity fault
`ifndef NRGD_MAP_VH
`define NRGD_MAP_VH

`define NRGD_ADDR_W 8
`define NRGD_DATA_W 16

// register offsets
`define NRGD_CTRL_OFS 8'h00
`define NRGD_STAT_OFS 8'h04
`define NRGD_ERR_OFS 8'h08
`define NRGD_MAINT_OFS 8'h0c
`define NRGD_LRC_OFS 8'h10

// control fields
`define NRGD_CTRL_SEL_LSB 0
`define NRGD_CTRL_SEL_MSB 2
`define NRGD_CTRL_SHORT_BIT 3
`define NRGD_CTRL_NOCORR_BIT 4
`define NRGD_CTRL_RESET 5'h00

// status fields
`define NRGD_STAT_CYC1_BIT 0
`define NRGD_STAT_CYC2_BIT 1
`define NRGD_STAT_CYC3_BIT 2
`define NRGD_STAT_SAC_BIT 3
`define NRGD_STAT_GAP_BIT 4
`define NRGD_STAT_TMARK_BIT 5
`define NRGD_STAT_WIN_BIT 6

// error fields, write one to clear
`define NRGD_ERR_CRC_BIT 0
`define NRGD_ERR_FLE_BIT 1
`define NRGD_ERR_NSG_BIT 2
`define NRGD_ERR_RESET 3'h0

// gap and tape mark counts
`define NRGD_GAP_EIGHT 4'h8
`define NRGD_GAP_FULL 4'hf
`define NRGD_GAP_LAST 4'he
`define NRGD_SPACE_PRESET 4'h6
`define NRGD_SPACE_LO 4'hc
`define NRGD_SPACE_FULL 4'hf
`define NRGD_MIN_LEN 4'ha
`define NRGD_MIN_SHORT 4'h4
`define NRGD_CCNT_FULL 4'hf

// 200 bpi gap clock: one character cell at 45 in/s, in ns
`define NRGD_CLK_NS 100
`define NRGD_GAP_CLK_NS 111111
`define NRGD_GAP_CLK_CYCLES (`NRGD_GAP_CLK_NS / `NRGD_CLK_NS)
`define NRGD_DIV_W 11

`endif

//--- sim/nrgd_checker.sv
// assertions for the read check and gap detect core
`timescale 1ns/1ps
`default_nettype none
`include "nrgd_map.vh"
module nrgd_checker (
  input wire core_clk_i,
  input wire resetn_i,
  input wire rd_i,
  input wire [`NRGD_DATA_W-1:0] rdata_o,
  input wire drive_setup_pulse_i,
  input wire cmd_launch_i,
  input wire reverse_i,
  input wire longit_char_done_i,
  input wire correctable_i,
  input wire char_valid_o,
  input wire end_record_strobe_o,
  input wire forward_longit_strobe_o,
  input wire longitudinal_ok_o,
  input wire slave_change_flag_o,
  input wire gap_count_eight_o,
  input wire tape_mark_flag_o,
  input wire cycle1_o,
  input wire cycle2_o,
  input wire cycle3_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_eight_then_mark;
    gap_count_eight_o ##1 $rose(tape_mark_flag_o);
  endsequence
  sequence s_end_once;
    end_record_strobe_o ##1 !end_record_strobe_o;
  endsequence
  a_fwd_strobe_gate: assert property (
    forward_longit_strobe_o == (longit_char_done_i && !reverse_i))
    else $error("forward strobe wrong");
  a_ok_in_cycle3: assert property (cycle3_o |-> longitudinal_ok_o)
    else $error("longitudinal ok low in cycle 3");
  a_cyc3_blocks_c1: assert property (
    cycle3_o && !cmd_launch_i |=> !$rose(cycle1_o))
    else $error("cycle 1 set during cycle 3");
  a_launch_ends_c3: assert property (
    cycle3_o && cmd_launch_i && correctable_i && !drive_setup_pulse_i |=> !cycle3_o)
    else $error("launch did not end cycle 3");
  a_sac_aborts: assert property (
    slave_change_flag_o && !drive_setup_pulse_i |=> !cycle1_o && !cycle2_o)
    else $error("select change did not abort");
  a_mark_after_eight: assert property (
    $rose(tape_mark_flag_o) |-> $past(gap_count_eight_o))
    else $error("tape mark without count 8");
  a_end_one_cycle: assert property (end_record_strobe_o |-> s_end_once)
    else $error("end strobe too long");
  a_char_one_cycle: assert property (char_valid_o |=> !char_valid_o)
    else $error("char valid too long");
  a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data outside its cycle");
  c_mark: cover property (s_eight_then_mark);
endmodule // nrgd_checker
bind nrgd_core nrgd_checker nrgd_checker_inst (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .drive_setup_pulse_i(drive_setup_pulse_i), .cmd_launch_i(cmd_launch_i),
  .reverse_i(reverse_i), .longit_char_done_i(longit_char_done_i),
  .correctable_i(correctable_i), .char_valid_o(char_valid_o),
  .end_record_strobe_o(end_record_strobe_o), .forward_longit_strobe_o(forward_longit_strobe_o),
  .longitudinal_ok_o(longitudinal_ok_o), .slave_change_flag_o(slave_change_flag_o),
  .gap_count_eight_o(gap_count_eight_o), .tape_mark_flag_o(tape_mark_flag_o),
  .cycle1_o(cycle1_o), .cycle2_o(cycle2_o), .cycle3_o(cycle3_o)
);
`default_nettype wire

//--- sim/nrgd_tape.sv
// transport model: read character pulses, tracks and character clock
`timescale 1ns/1ps
`default_nettype none
module nrgd_tape (
  // clock and requests
  input wire logic core_clk_i,
  input wire logic send_i,
  input wire logic run_i,
  input wire logic [8:0] data_i,
  // transport pins
  output logic read_char_detect_o,
  output logic [8:0] read_char_data_o,
  output logic transport_char_clock_o
);
  logic [3:0] cnt = 4'h0;
  logic [1:0] ck = 2'h0;
  logic tck = 1'b0;
  logic [8:0] dat = 9'h000;
  always @(posedge core_clk_i) begin
    if (send_i) begin
      dat <= data_i;
      cnt <= 4'h1;
    end else if (cnt != 4'h0) begin
      cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
    end
    // clock stands still while the tape is not moving
    if (run_i) begin
      ck <= ck + 2'h1;
      if (ck == 2'h3) begin
        tck <= ~tck;
      end
    end
  end
  // tracks settle two clocks before the pulse; idle shows the inverse
  assign read_char_data_o = (cnt != 4'h0) ? dat : ~dat;
  assign read_char_detect_o = (cnt >= 4'h3) && (cnt <= 4'h5);
  assign transport_char_clock_o = tck;
endmodule // nrgd_tape
`default_nettype wire

//--- sim/nrzi_read_check_gap_detect_test.sv
// self-checking bench for the read check and gap detect core
`timescale 1ns/1ps
`default_nettype none
`include "nrgd_map.vh"
module nrzi_read_check_gap_detect_test;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, send = 0, run = 0;
  logic [7:0] addr = 0;
  logic [15:0] wdata = 0, rdata, v;
  logic [8:0] cdat = 0, pdat, chr;
  logic [2:0] ctl = 0;
  logic rev = 0, wop = 0, rdg = 1, gtd = 0, crc = 0, cor = 0;
  wire pdet, pclk, ers, fls, lok, slave_change_flag, g8, gdet, tmk, c1, c2, c3, cv;
  int n_mismatch = 0, tests_run = 0, i;
  initial forever #50 clk = ~clk;
  nrgd_tape nrgd_tape_inst (.core_clk_i(clk), .send_i(send), .run_i(run), .data_i(cdat),
    .read_char_detect_o(pdet), .read_char_data_o(pdat), .transport_char_clock_o(pclk));
  nrgd_core nrgd_core_inst (.core_clk_i(clk), .resetn_i(rstn), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .read_char_detect_i(pdet),
    .read_char_data_i(pdat), .transport_char_clock_i(pclk), .drive_setup_pulse_i(ctl[0]),
    .cmd_launch_i(ctl[2]), .reverse_i(rev), .write_op_i(wop), .reading_i(rdg),
    .gap_timer_done_i(gtd), .longit_char_done_i(ctl[1]), .crc_mismatch_i(crc),
    .correctable_i(cor), .incorrectable_i(1'b0), .err_track_i(4'h0), .char_o(chr),
    .char_valid_o(cv), .end_record_strobe_o(ers), .forward_longit_strobe_o(fls),
    .longitudinal_ok_o(lok), .slave_change_flag_o(slave_change_flag), .gap_count_eight_o(g8),
    .gap_detected_o(gdet), .tape_mark_flag_o(tmk), .cycle1_o(c1), .cycle2_o(c2),
    .cycle3_o(c3));
  task chk(input bit ok, input string m);
    tests_run++;
    if (!ok) begin
      n_mismatch++;
      $display("Error at %0t ns: %s", $time, m);
    end
  endtask
  task wr_reg(input [7:0] a, input [15:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1;
    @(posedge clk); wr <= 0;
  endtask
  task rd_reg(input [7:0] a);
    @(posedge clk); addr <= a; rd <= 1;
    @(posedge clk); rd <= 0;
    #1 v = rdata;
  endtask
  task pulse(input [2:0] m);
    @(posedge clk); ctl <= m;
    @(posedge clk); ctl <= 0;
    #1;
  endtask
  task sendc(input [8:0] d);
    @(posedge clk); cdat <= d; send <= 1;
    @(posedge clk); send <= 0;
    repeat (12) @(posedge clk);
  endtask
  // the short-record logic only restarts after reading drops
  task restart;
    rdg <= 0;
    repeat (3) @(posedge clk);
    pulse(3'h1);
    rdg <= 1;
  endtask
  task t_regs;
    rd_reg(`NRGD_CTRL_OFS); chk(v === 16'h0000, "ctrl reset");
    rd_reg(8'h14); chk(v === 16'h0000, "unmapped read");
    wr_reg(`NRGD_CTRL_OFS, 16'h0003); #1 chk(slave_change_flag === 1'b1, "no select flag");
    pulse(3'h1); chk(slave_change_flag === 1'b0, "setup kept flag");
    $display("t_regs done");
  endtask
  task t_lrc;
    pulse(3'h1); sendc(9'h001); sendc(9'h003);
    rd_reg(`NRGD_LRC_OFS); chk(v === 16'h0002, "check register");
    sendc(9'h002); pulse(3'h2);
    rd_reg(`NRGD_ERR_OFS); chk(v === 16'h0000, "good record flagged");
    rd_reg(`NRGD_MAINT_OFS); chk(v === 16'h0002, "last char lost");
    pulse(3'h1); sendc(9'h005); pulse(3'h2);
    rd_reg(`NRGD_ERR_OFS); chk(v === 16'h0002, "no longitudinal error");
    wr_reg(`NRGD_ERR_OFS, 16'h0007); rev <= 1; pulse(3'h2); rev <= 0;
    rd_reg(`NRGD_ERR_OFS); chk(v === 16'h0000, "reverse read flagged");
    $display("t_lrc done");
  endtask
  task t_corr;
    pulse(3'h1); crc <= 1; pulse(3'h2); crc <= 0;
    chk(c1 === 1'b1, "no cycle 1");
    rd_reg(`NRGD_ERR_OFS); chk(v[0] === 1'b1, "no cyclic error");
    rev <= 1; pulse(3'h1); rev <= 0; chk(c2 === 1'b1, "no cycle 2");
    pulse(3'h1); chk({c3, c2, c1} === 3'b100, "no cycle 3");
    sendc(9'h003); chk(chr === 9'h002, "track not repaired");
    sendc(9'h001); crc <= 1; pulse(3'h2); crc <= 0;
    chk({c1, lok} === 2'b01, "cycle 3 not held");
    cor <= 1; pulse(3'h4); cor <= 0; chk(c3 === 1'b0, "cycle 3 not ended");
    pulse(3'h1); crc <= 1; pulse(3'h2); crc <= 0;
    wr_reg(`NRGD_CTRL_OFS, 16'h0002); @(posedge clk);
    #1 chk(c1 === 1'b0, "no abort");
    pulse(3'h1); crc <= 1; pulse(3'h2); crc <= 0;
    @(posedge clk); rstn <= 0;
    @(posedge clk); #1 chk(c1 === 1'b0, "reset kept cycle 1");
    @(posedge clk); rstn <= 1;
    $display("t_corr done");
  endtask
  task t_gap;
    restart;
    for (int k = 0; k < 10; k++) sendc(k[8:0]);
    for (i = 0; i < 20000 && gdet !== 1'b1; i++) @(posedge clk);
    chk(gdet === 1'b1 && i > 15000, "gap timing");
    $display("t_gap done");
  endtask
  task t_mark;
    restart;
    run <= 1;
    sendc(9'h0f0); repeat (40) @(posedge clk); sendc(9'h0f0);
    for (i = 0; i < 12000 && tmk !== 1'b1; i++) @(posedge clk);
    chk(tmk === 1'b1 && gdet === 1'b0, "tape mark");
    run <= 0;
    $display("t_mark done");
  endtask
  task t_nsg;
    wop <= 1; gtd <= 1; restart;
    for (int k = 0; k < 10; k++) sendc(9'h100 | k[8:0]);
    for (i = 0; i < 12000 && g8 !== 1'b1; i++) @(posedge clk);
    sendc(9'h011);
    rd_reg(`NRGD_ERR_OFS); chk(v[2] === 1'b1, "no nonstandard gap");
    wop <= 0; gtd <= 0;
    $display("t_nsg done");
  endtask
  task final_report;
    $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1;
    t_regs; t_lrc; t_corr; t_gap; t_mark; t_nsg;
    final_report;
  end
  // whole run is near 35000 cycles
  initial begin
    #8000000;
    n_mismatch++;
    final_report;
  end
endmodule // nrzi_read_check_gap_detect_test
`default_nettype wire
